/* File: verilog/nvm_access_consts.svh */
/*
  Constants for the byte-wide nonvolatile access block: register select codes,
  control bit positions, reset values and array timing.
  Assumes it is included by bare name from files under verilog/.
*/
`ifndef NVM_ACCESS_CONSTS_SVH
`define NVM_ACCESS_CONSTS_SVH

`define REG_SEL_ADDRESS 2'h0
`define REG_SEL_DATA 2'h1
`define REG_SEL_CONTROL 2'h2

`define CTL_FETCH_START 0
`define CTL_FETCH_ENABLE 1
`define CTL_WRITE_START 2
`define CTL_PROGRAM_ENABLE 3

`define CTL_RESET 4'h0
`define BYTE_ZERO 8'h00
`define ADDR_RESET 8'h00

`define WRITE_TIME_US 2
`define CLK_MHZ 100
`define READ_CYCLES 2

`endif

/* File: verilog/nvm_access_pkg.sv */
/*
  Types shared by the nonvolatile access block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package nvm_access_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WRITE = 2'h1,
    ST_READ = 2'h2
  } nvm_state_t;
endpackage
`default_nettype wire

/* File: verilog/nvm_cycle_timer.sv */
/*
  Down-counter that measures one array cycle and pulses when it expires.
  Assumes start is a single-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module nvm_cycle_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [WIDTH-1:0] count_i,
  output logic busy_o,
  output logic done_o
);
  logic [WIDTH-1:0] cnt_q;
  wire logic last = busy_o && (cnt_q == '0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= last;
      if (start_i) begin
        cnt_q <= count_i;
        busy_o <= 1'b1;
      end else if (last) begin
        busy_o <= 1'b0;
      end else if (busy_o) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/nvm_access.sv */
/*
  Byte-wide nonvolatile data array with its address, data and control
  registers, reached over a simple byte register port.
  Assumes a single 100 MHz clock and register accesses from logic on it.
*/
// How it works
// - address register is 8-bit, read/write, no reset
// - control bits 7..4 always read zero
// - writes refused while program enable is low
// - write start stores data byte at address
// - hardware clears write start on completion
// - write start ignored unless enable previously set
// - write start reads zero when nothing pending
// - read start ignored unless fetch enable set
// - read start clears; byte held in data
// - write end sets done and shared flags
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_consts.svh"
module nvm_access #(
  parameter int DEPTH = 256,
  parameter int WRITE_CYCLES = `WRITE_TIME_US * `CLK_MHZ
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic REG_WE_I,
  input wire logic REG_RE_I,
  input wire logic [1:0] REG_SEL_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic DONE_CLR_I,
  output logic [7:0] REG_RDATA_O,
  output logic NVM_DONE_FLAG_O,
  output logic SHARED_IRQ_FLAG_O,
  output logic WRITE_BUSY_O
);
  localparam int TW = 16;
  localparam logic [TW-1:0] WR_CNT = TW'(WRITE_CYCLES - 1);
  localparam logic [TW-1:0] RD_CNT = TW'(`READ_CYCLES - 1);

  logic [7:0] array_q [DEPTH];
  logic [7:0] nvm_address_q;
  logic [7:0] nvm_data_byte_q;
  logic program_enable_q, write_start_q, fetch_enable_q, fetch_start_q;
  logic [7:0] cyc_addr_q;
  nvm_access_pkg::nvm_state_t state_q, state_d;
  logic t_busy, t_done;

  wire logic [7:0] wd = REG_WDATA_I;
  wire logic wr_addr = REG_WE_I && (REG_SEL_I == `REG_SEL_ADDRESS);
  wire logic wr_data = REG_WE_I && (REG_SEL_I == `REG_SEL_DATA);
  wire logic wr_ctl = REG_WE_I && (REG_SEL_I == `REG_SEL_CONTROL);
  wire logic idle = (state_q == nvm_access_pkg::ST_IDLE);
  // start only if enable was already set before this write
  wire logic go_write = wr_ctl && wd[`CTL_WRITE_START] && program_enable_q
    && idle && !write_start_q;
  wire logic go_read = wr_ctl && wd[`CTL_FETCH_START] && fetch_enable_q
    && idle && !fetch_start_q && !go_write;
  wire logic wr_end = (state_q == nvm_access_pkg::ST_WRITE) && t_done;
  wire logic rd_end = (state_q == nvm_access_pkg::ST_READ) && t_done;
  wire logic [7:0] ctl_rd = {4'h0, program_enable_q, write_start_q,
    fetch_enable_q, fetch_start_q};
  wire logic [7:0] rd_mux = (REG_SEL_I == `REG_SEL_ADDRESS) ? nvm_address_q :
    (REG_SEL_I == `REG_SEL_DATA) ? nvm_data_byte_q :
    (REG_SEL_I == `REG_SEL_CONTROL) ? ctl_rd : `BYTE_ZERO;
  wire logic [TW-1:0] t_count = go_write ? WR_CNT : RD_CNT;
  wire logic [7:0] cyc_idx = 8'(int'(cyc_addr_q) % DEPTH);
  wire logic [7:0] cell_rd = array_q[cyc_idx];

  nvm_cycle_timer #(.WIDTH(TW)) u_timer (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .start_i(go_write || go_read),
    .count_i(t_count),
    .busy_o(t_busy),
    .done_o(t_done)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      nvm_access_pkg::ST_IDLE: begin
        if (go_write) state_d = nvm_access_pkg::ST_WRITE;
        else if (go_read) state_d = nvm_access_pkg::ST_READ;
      end
      nvm_access_pkg::ST_WRITE: begin
        if (t_done) state_d = nvm_access_pkg::ST_IDLE;
      end
      nvm_access_pkg::ST_READ: begin
        if (t_done) state_d = nvm_access_pkg::ST_IDLE;
      end
      default: state_d = nvm_access_pkg::ST_IDLE;
    endcase
  end

  // address has no reset value in the array's own sense
  always_ff @(posedge CLK_I) begin
    if (wr_addr) nvm_address_q <= wd;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_q <= nvm_access_pkg::ST_IDLE;
      {program_enable_q, write_start_q, fetch_enable_q, fetch_start_q} <= `CTL_RESET;
      cyc_addr_q <= `ADDR_RESET;
    end else begin
      state_q <= state_d;
      if (wr_ctl) begin
        program_enable_q <= wd[`CTL_PROGRAM_ENABLE];
        fetch_enable_q <= wd[`CTL_FETCH_ENABLE];
      end
      if (go_write) write_start_q <= 1'b1;
      else if (wr_end) write_start_q <= 1'b0;
      if (go_read) fetch_start_q <= 1'b1;
      else if (rd_end) fetch_start_q <= 1'b0;
      if (go_write || go_read) cyc_addr_q <= nvm_address_q;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      nvm_data_byte_q <= `BYTE_ZERO;
    end else if (rd_end) begin
      nvm_data_byte_q <= cell_rd;
    end else if (wr_data && idle) begin
      nvm_data_byte_q <= wd;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (wr_end) array_q[cyc_idx] <= nvm_data_byte_q;
  end

  // set wins over software clear
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      NVM_DONE_FLAG_O <= 1'b0;
      SHARED_IRQ_FLAG_O <= 1'b0;
      REG_RDATA_O <= `BYTE_ZERO;
      WRITE_BUSY_O <= 1'b0;
    end else begin
      if (wr_end) NVM_DONE_FLAG_O <= 1'b1;
      else if (DONE_CLR_I) NVM_DONE_FLAG_O <= 1'b0;
      if (wr_end) SHARED_IRQ_FLAG_O <= 1'b1;
      else if (DONE_CLR_I) SHARED_IRQ_FLAG_O <= 1'b0;
      if (REG_RE_I) REG_RDATA_O <= rd_mux;
      WRITE_BUSY_O <= write_start_q && t_busy;
    end
  end

  AST_NO_WRITE_WITHOUT_ENABLE: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (wr_ctl && wd[`CTL_WRITE_START] && !program_enable_q && !write_start_q)
    |=> !write_start_q) else $error("write started without program enable");
  AST_WRITE_STARTS: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    go_write |=> write_start_q && state_q == nvm_access_pkg::ST_WRITE)
    else $error("write start not taken");
  AST_WRITE_CLEARS: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    go_write |-> ##[2:1000] !write_start_q) else $error("write start never cleared");
  AST_WRITE_HOLDS: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    go_write |=> write_start_q[*2]) else $error("write start dropped early");
  AST_CTL_UPPER_ZERO: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    $past(REG_RE_I) && $past(REG_SEL_I) == `REG_SEL_CONTROL |-> REG_RDATA_O[7:4] == 4'h0)
    else $error("upper control bits not zero");
  AST_NO_READ_WITHOUT_ENABLE: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (wr_ctl && wd[`CTL_FETCH_START] && !fetch_enable_q && !fetch_start_q)
    |=> !fetch_start_q) else $error("read started without fetch enable");
  AST_READ_CLEARS: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    go_read |-> ##[2:8] !fetch_start_q) else $error("read start never cleared");
  AST_DONE_ON_END: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    wr_end |=> NVM_DONE_FLAG_O && SHARED_IRQ_FLAG_O) else $error("done flag not set");
  AST_ADDR_WRITE: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    wr_addr |=> nvm_address_q == $past(REG_WDATA_I)) else $error("address not stored");
  AST_POLL_IDLE: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    !write_start_q |-> state_q != nvm_access_pkg::ST_WRITE)
    else $error("write pending with start bit low");
  AST_WRITE_ENDS_CLEARED: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    wr_end |=> !write_start_q && state_q == nvm_access_pkg::ST_IDLE)
    else $error("write start still set after cycle end");
  AST_POLL_READS_START: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    $past(REG_RE_I) && $past(REG_SEL_I) == `REG_SEL_CONTROL
    |-> REG_RDATA_O[`CTL_WRITE_START] == $past(write_start_q))
    else $error("control read does not show write start");
  AST_ENABLES_STORED: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    wr_ctl |=> program_enable_q == $past(REG_WDATA_I[`CTL_PROGRAM_ENABLE])
    && fetch_enable_q == $past(REG_WDATA_I[`CTL_FETCH_ENABLE]))
    else $error("enable bits not stored");
  AST_FETCH_STARTS: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    go_read |=> fetch_start_q && state_q == nvm_access_pkg::ST_READ)
    else $error("read start not taken");
  AST_FETCH_ENDS_CLEARED: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    rd_end |=> !fetch_start_q && nvm_data_byte_q == $past(cell_rd))
    else $error("read end did not clear start or load byte");
  AST_DATA_STANDS: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    !rd_end && !(wr_data && idle) |=> $stable(nvm_data_byte_q))
    else $error("data byte changed without read or write");
  AST_BUSY_SHOWS_WRITE: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    write_start_q && t_busy |=> WRITE_BUSY_O)
    else $error("busy output missing during write");
  AST_DONE_CLEARED: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    DONE_CLR_I && !wr_end |=> !NVM_DONE_FLAG_O && !SHARED_IRQ_FLAG_O)
    else $error("done flags not cleared by software");
  AST_DONE_STICKY: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    NVM_DONE_FLAG_O && !DONE_CLR_I |=> NVM_DONE_FLAG_O)
    else $error("done flag dropped without clear");
  AST_ONE_CYCLE_AT_A_TIME: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    !(write_start_q && fetch_start_q)) else $error("read and write cycles overlap");
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
/*
  Self-checking bench for the nonvolatile access block: register table rows,
  then refused-start, write, read and mid-write reset cases by hand.
  Assumes the design files under verilog/ are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic clr = 1'b0;
  logic [7:0] rdata;
  logic done_flag;
  logic shared_flag;
  logic busy;
  logic [7:0] v;
  int err_total = 0;
  int checks_done = 0;
  typedef struct {logic [1:0] s; logic [7:0] w; logic [7:0] r;} row_t;
  row_t rows [7] = '{'{2'h0, 8'hA5, 8'hA5}, '{2'h0, 8'h00, 8'h00}, '{2'h0, 8'hFF, 8'hFF},
    '{2'h2, 8'hF2, 8'h02}, '{2'h2, 8'h00, 8'h00}, '{2'h3, 8'h77, 8'h00},
    '{2'h1, 8'h3C, 8'h3C}};

  nvm_access #(.WRITE_CYCLES(4)) i_dut (.CLK_I(clk), .SYS_RST_I(rst), .REG_WE_I(we),
    .REG_RE_I(re), .REG_SEL_I(sel), .REG_WDATA_I(wdata), .DONE_CLR_I(clr),
    .REG_RDATA_O(rdata), .NVM_DONE_FLAG_O(done_flag), .SHARED_IRQ_FLAG_O(shared_flag),
    .WRITE_BUSY_O(busy));

  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk);
    #1 we = 1'b1;
    sel = s;
    wdata = d;
    @(posedge clk);
    #1 we = 1'b0;
  endtask

  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    @(posedge clk);
    #1 re = 1'b1;
    sel = s;
    @(posedge clk);
    #1 re = 1'b0;
    d = rdata;
  endtask

  // poll a control bit until it drops, bounded
  task automatic poll(input int b);
    int n;
    n = 0;
    rd(2'h2, v);
    while (v[b] !== 1'b0 && n < 50) begin
      rd(2'h2, v);
      n++;
    end
    chk("start bit cleared", 1'b0, v[b]);
  endtask

  task automatic test_done();
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    rd(2'h2, v);
    chk("control after reset", 8'h00, v);
    chk("flags after reset", 8'h00, {done_flag, shared_flag, busy});
    foreach (rows[i]) begin
      wr(rows[i].s, rows[i].w);
      rd(rows[i].s, v);
      chk("row readback", rows[i].r, v);
    end
    wr(2'h2, 8'h04);
    rd(2'h2, v);
    chk("write start without enable", 8'h00, v);
    wr(2'h2, 8'h01);
    rd(2'h2, v);
    chk("read start without enable", 8'h00, v);
    chk("no done flag", 1'b0, done_flag);
    wr(2'h0, 8'h5A);
    wr(2'h1, 8'hC3);
    wr(2'h2, 8'h08);
    wr(2'h2, 8'h0C);
    rd(2'h2, v);
    chk("write pending", 8'h0C, v);
    chk("busy during write", 8'h01, busy);
    wr(2'h1, 8'hEE);
    poll(2);
    chk("busy after write", 8'h00, busy);
    rd(2'h2, v);
    chk("control after write", 8'h08, v);
    rd(2'h1, v);
    chk("data kept during write", 8'hC3, v);
    chk("done flag", 1'b1, done_flag);
    chk("shared flag", 1'b1, shared_flag);
    @(posedge clk);
    #1 clr = 1'b1;
    @(posedge clk);
    #1 clr = 1'b0;
    @(posedge clk);
    #1 chk("flags cleared", 2'b00, {done_flag, shared_flag});
    wr(2'h1, 8'h11);
    wr(2'h2, 8'h02);
    wr(2'h2, 8'h03);
    poll(0);
    rd(2'h1, v);
    chk("byte fetched", 8'hC3, v);
    rd(2'h1, v);
    chk("byte held", 8'hC3, v);
    // reset in the middle of a write cycle
    wr(2'h2, 8'h08);
    wr(2'h2, 8'h0C);
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    rd(2'h2, v);
    chk("control after mid reset", 8'h00, v);
    chk("flags after mid reset", 8'h00, {done_flag, shared_flag, busy});
    rd(2'h1, v);
    chk("data after mid reset", 8'h00, v);
    wr(2'h2, 8'h02);
    wr(2'h2, 8'h03);
    poll(0);
    rd(2'h1, v);
    chk("array kept over reset", 8'hC3, v);
    test_done();
  end
endmodule
`default_nettype wire
